//--- dom_timeout_guard.sv
// dom_timeout_guard: watches one bus for an over-long dominant level
// assumes bus_dominant is synchronous to clk_sys
`timescale 1ns/10ps
`include "lin_status_regs.svh"

module dom_timeout_guard
#(
   parameter int unsigned TIMEOUT_CYCLES = `DOM_TIMEOUT_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic bus_dominant,
   output logic term_allowed,
   output logic timed_out
);
   import lin_status_pkg::*;

   dom_state_type state_reg; // registered state
   dom_state_type state_next; // next state

   // count dominant cycles; saturates so a stuck bus never wraps back on
   always_comb
   begin
      state_next = state_reg;
      if (!bus_dominant)
      begin
         state_next.mode = TERM_CONNECTED;
         state_next.count = '0;
      end
      else
      begin
         unique case (state_reg.mode)
            TERM_CONNECTED:
            begin
               if (state_reg.count >= TIMEOUT_CYCLES[`DOM_CNT_W-1:0])
               begin
                  state_next.mode = TERM_DISCONNECTED;
               end
               else
               begin
                  state_next.count = state_reg.count + 1'b1;
               end
            end
            TERM_DISCONNECTED:
            begin
               state_next.count = state_reg.count; // hold until recessive
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign timed_out = (state_reg.mode == TERM_DISCONNECTED);
   assign term_allowed = (state_reg.mode == TERM_CONNECTED);
endmodule : dom_timeout_guard

//--- lin_bus_model.sv
// lin_bus_model: the four buses with their slave nodes
// assumes slave_dom is driven by the bench just after a clock edge
`timescale 1ns/10ps
module lin_bus_model
(
   input wire logic [3:0] lin_tx_out,
   input wire logic [3:0] slave_dom,
   output logic [3:0] bus_dominant
);
   // wired-and: recessive only when master and every slave let go
   assign bus_dominant = ~lin_tx_out | slave_dom;
endmodule : lin_bus_model

//--- lin_frame_status_flags.sv
// lin_frame_status_flags: frame status flags, status interrupts, bus drive
// and termination control for four channels
// assumes the frame controller gives one-cycle event pulses on clk_sys
// and that register reads/writes arrive as single-cycle strobes
`timescale 1ns/10ps
`include "lin_status_regs.svh"

module lin_frame_status_flags
#(
   // long count; shorten in simulation
   parameter int unsigned DOM_TIMEOUT_CYCLES = `DOM_TIMEOUT_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // per-channel control levels
   input wire logic [3:0] init_mode,
   input wire logic [3:0] normal_mode,
   input wire logic [3:0] low_power_mode,
   input wire logic [3:0] idle_on_bit_error,
   input wire logic [3:0] response_dir,
   input wire logic [3:0] rx_complete_irq_enable,
   input wire logic [3:0] tx_complete_irq_enable,
   input wire logic [3:0] channel_status_irq_enable,
   input wire lin_status_pkg::pullup_cfg_type [3:0] pullup_cfg,
   // per-channel event pulses from the frame controller
   input wire logic [3:0] rx_response_done,
   input wire logic [3:0] rx_frame_error,
   input wire logic [3:0] rx_checksum_error,
   input wire logic [3:0] first_byte_stored,
   input wire logic [3:0] tx_response_start,
   input wire logic [3:0] tx_response_done,
   input wire logic [3:0] tx_bit_error,
   // bus side
   input wire logic [3:0] tx_active,
   input wire logic [3:0] tx_bit,
   input wire logic [3:0] bus_dominant,
   output logic [3:0] lin_tx_out,
   output logic [3:0] master_pullup,
   output logic [3:0] low_power_master_pullup,
   output logic [3:0] weak_slave_pullup,
   output logic [3:0] dom_timeout_active,
   // status outputs
   output logic [3:0] channel_status_irq,
   output logic [3:0] err_frame_set,
   output logic [3:0] err_checksum_set,
   output logic [3:0] err_bit_set
);
   import lin_status_pkg::*;

   // status register offsets, one per channel
   localparam logic [3:0][7:0] STATUS_OFFS =
      {`CH4_STATUS_OFFS, `CH3_STATUS_OFFS, `CH2_STATUS_OFFS, `CH1_STATUS_OFFS};

   top_state_type state_reg; // all registered state
   top_state_type state_next; // next value of the state
   logic [3:0] term_allowed; // per-channel termination permission

   // next-state logic for every channel plus the register port
   always_comb
   begin
      logic wr_hit; // write lands on this channel's status register
      logic clr_rx; // write-one-to-clear requests
      logic clr_tx;
      logic clr_buf;
      logic set_rx; // hardware set requests
      logic set_tx;
      logic set_buf;
      logic rx_err_now; // error reported in this very cycle
      logic [7:0] rd_word; // assembled read value
      wr_hit = 1'b0;
      clr_rx = 1'b0;
      clr_tx = 1'b0;
      clr_buf = 1'b0;
      set_rx = 1'b0;
      set_tx = 1'b0;
      set_buf = 1'b0;
      rx_err_now = 1'b0;
      rd_word = `STATUS_RESET;
      state_next = state_reg;
      state_next.rvalid = 1'b0;

      for (int ch = 0; ch < 4; ch++)
      begin
         // software clear: a one clears, a zero leaves the flag alone
         wr_hit = reg_wr && (reg_addr == STATUS_OFFS[ch]);
         clr_rx = wr_hit && reg_wdata[`RXDONE_BIT];
         clr_tx = wr_hit && reg_wdata[`TXDONE_BIT];
         clr_buf = wr_hit && reg_wdata[`RXBUF_BIT];

         // reception: flag only when no framing/checksum error in the frame
         rx_err_now = rx_frame_error[ch] || rx_checksum_error[ch];
         set_rx = rx_response_done[ch] && !rx_err_now
            && !state_reg.chan[ch].rx_err_seen;

         // transmission: a bit error only blocks the flag with idle-on-error
         set_tx = tx_response_done[ch]
            && !(idle_on_bit_error[ch]
            && (tx_bit_error[ch] || state_reg.chan[ch].tx_err_seen));

         // buffer flag: first stored byte, or a response we send ourselves
         set_buf = first_byte_stored[ch]
            || (tx_response_start[ch] && response_dir[ch]);

         // set beats clear, so an event landing on a clear is kept
         state_next.chan[ch].rx_done_flag =
            set_rx || (state_reg.chan[ch].rx_done_flag && !clr_rx);
         state_next.chan[ch].tx_done_flag =
            set_tx || (state_reg.chan[ch].tx_done_flag && !clr_tx);
         state_next.chan[ch].rxbuf_flag =
            set_buf || (state_reg.chan[ch].rxbuf_flag && !clr_buf);

         // frame error trackers: cleared when the frame ends
         if (rx_response_done[ch])
         begin
            state_next.chan[ch].rx_err_seen = 1'b0;
         end
         else if (rx_err_now)
         begin
            state_next.chan[ch].rx_err_seen = 1'b1;
         end
         if (tx_response_done[ch])
         begin
            state_next.chan[ch].tx_err_seen = 1'b0;
         end
         else if (tx_bit_error[ch])
         begin
            state_next.chan[ch].tx_err_seen = 1'b1;
         end

         // init mode wipes the flags and frame error trackers; nothing runs in it anyway
         if (init_mode[ch])
         begin
            state_next.chan[ch].rx_done_flag = 1'b0;
            state_next.chan[ch].tx_done_flag = 1'b0;
            state_next.chan[ch].rxbuf_flag = 1'b0;
            state_next.chan[ch].rx_err_seen = 1'b0;
            state_next.chan[ch].tx_err_seen = 1'b0;
         end

         // error register set pulses, one cycle after the event
         state_next.chan[ch].err_frame = rx_frame_error[ch];
         state_next.chan[ch].err_checksum = rx_checksum_error[ch];
         // the bit error flag is raised whether or not the frame stops
         state_next.chan[ch].err_bit = tx_bit_error[ch];

         // status interrupt follows the flags that will be stored
         state_next.chan[ch].status_irq = channel_status_irq_enable[ch]
            && ((state_next.chan[ch].rx_done_flag
            && rx_complete_irq_enable[ch])
            || (state_next.chan[ch].tx_done_flag
            && tx_complete_irq_enable[ch]));

         // bus drive: recessive (high) unless normal mode and transmitting
         state_next.chan[ch].tx_line =
            (normal_mode[ch] && tx_active[ch]) ? tx_bit[ch] : 1'b1;

         // read value: pre-write contents, reserved bits zero
         if (reg_addr == STATUS_OFFS[ch])
         begin
            rd_word[`RXBUF_BIT] = state_reg.chan[ch].rxbuf_flag;
            rd_word[`RXDONE_BIT] = state_reg.chan[ch].rx_done_flag;
            rd_word[`TXDONE_BIT] = state_reg.chan[ch].tx_done_flag;
         end
      end

      // read answer one cycle after the strobe; unmapped reads give zero
      if (reg_rd)
      begin
         state_next.rdata = rd_word;
         state_next.rvalid = 1'b1;
      end
   end

   // single state register; async reset to constants only
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= '0;
         // the bus idles recessive from reset onward
         for (int ch = 0; ch < 4; ch++)
         begin
            state_reg.chan[ch].tx_line <= 1'b1;
         end
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // termination path: timeout guard feeds the pull-up selector
   for (genvar ch = 0; ch < 4; ch++)
   begin : g_term
      // dominant timeout per channel
      dom_timeout_guard
      #(
         .TIMEOUT_CYCLES(DOM_TIMEOUT_CYCLES)
      )
      u_guard
      (
         .clk_sys(clk_sys),
         .rst_b(rst_b),
         .bus_dominant(bus_dominant[ch]),
         .term_allowed(term_allowed[ch]),
         .timed_out(dom_timeout_active[ch])
      );

      // pull-up switch selection per channel
      termination_select u_select
      (
         .clk_sys(clk_sys),
         .rst_b(rst_b),
         .cfg(pullup_cfg[ch]),
         .low_power(low_power_mode[ch]),
         .term_allowed(term_allowed[ch]),
         .master_on(master_pullup[ch]),
         .lp_master_on(low_power_master_pullup[ch]),
         .slave_on(weak_slave_pullup[ch])
      );

      // registered per-channel outputs
      assign channel_status_irq[ch] = state_reg.chan[ch].status_irq;
      assign lin_tx_out[ch] = state_reg.chan[ch].tx_line;
      assign err_frame_set[ch] = state_reg.chan[ch].err_frame;
      assign err_checksum_set[ch] = state_reg.chan[ch].err_checksum;
      assign err_bit_set[ch] = state_reg.chan[ch].err_bit;
   end

   // register port answer
   assign reg_rdata = state_reg.rdata;
   assign reg_rvalid = state_reg.rvalid;
endmodule : lin_frame_status_flags

//--- lin_frame_status_flags_bench.sv
// lin_frame_status_flags_bench: register and event tests for the status block
// assumes the design files and lin_bus_model are compiled first
`timescale 1ns/10ps
module lin_frame_status_flags_bench;
   import lin_status_pkg::*;
   localparam int unsigned TMO = 8; // shortened dominant timeout
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
   logic [3:0] init_mode = 4'h0, normal_mode = 4'hf, low_power_mode = 4'h0;
   logic [3:0] idle_on_bit_error = 4'h0, response_dir = 4'h0, tx_complete_irq_enable = 4'h0;
   logic [3:0] rx_complete_irq_enable = 4'hf, channel_status_irq_enable = 4'hf;
   pullup_cfg_type [3:0] pullup_cfg = {4{2'h1}};
   logic [3:0] rx_response_done = 4'h0, rx_frame_error = 4'h0, rx_checksum_error = 4'h0;
   logic [3:0] first_byte_stored = 4'h0, tx_response_start = 4'h0, tx_response_done = 4'h0;
   logic [3:0] tx_bit_error = 4'h0, tx_active = 4'h0, tx_bit = 4'hf, slave_dom = 4'h0;
   logic [3:0] bus_dominant, lin_tx_out, master_pullup, low_power_master_pullup;
   logic [3:0] weak_slave_pullup, dom_timeout_active, channel_status_irq;
   logic [3:0] err_frame_set, err_checksum_set, err_bit_set;
   logic [1:0] term_exp;
   logic [7:0] offs [4] = '{8'h51, 8'h81, 8'hb1, 8'he1};
   int n_errors = 0, comparisons = 0, n;
   lin_frame_status_flags #(.DOM_TIMEOUT_CYCLES(TMO)) i_lin_frame_status_flags (.clk_sys,
      .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .init_mode,
      .normal_mode, .low_power_mode, .idle_on_bit_error, .response_dir,
      .rx_complete_irq_enable, .tx_complete_irq_enable, .channel_status_irq_enable,
      .pullup_cfg, .rx_response_done, .rx_frame_error, .rx_checksum_error,
      .first_byte_stored, .tx_response_start, .tx_response_done, .tx_bit_error, .tx_active,
      .tx_bit, .bus_dominant, .lin_tx_out, .master_pullup, .low_power_master_pullup,
      .weak_slave_pullup, .dom_timeout_active, .channel_status_irq, .err_frame_set,
      .err_checksum_set, .err_bit_set);
   lin_bus_model i_lin_bus_model (.lin_tx_out, .slave_dom, .bus_dominant);
   // 25 MHz system clock
   always #20 clk_sys = ~clk_sys;
   // inputs always move 1 ns after the rising edge
   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
         begin
            n_errors++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
         end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
   endtask : wr
   // read answer is registered: valid exactly one edge after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      tick;
      reg_rd = 1'b0;
      chk({7'h00, reg_rvalid}, 8'h01);
      chk(reg_rdata, exp);
      // one idle edge, so a following strobe is never re-raised in the same step
      tick;
   endtask : rd
   task automatic results;
      if (n_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   // watchdog: tests need under two hundred cycles
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      n_errors++;
      results;
   end
   initial
   begin
      repeat (4) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      tick;
      chk({4'h0, weak_slave_pullup}, 8'h0f);
      chk({4'h0, lin_tx_out}, 8'h0f);
      rd(8'h50, 8'h00);
      // every channel: set, write zero bits, write one, read back
      for (int k = 0; k < 4; k++)
      begin
         rd(offs[k], 8'h00);
         rx_response_done = 4'(1 << k);
         tick;
         rx_response_done = 4'h0;
         rd(offs[k], 8'h04);
         wr(offs[k], 8'hfb);
         rd(offs[k], 8'h04);
         wr(offs[k], 8'h04);
         rd(offs[k], 8'h00);
      end
      rx_response_done[0] = 1'b1;
      tick;
      rx_response_done[0] = 1'b0;
      chk({7'h0, channel_status_irq[0]}, 8'h01);
      channel_status_irq_enable[0] = 1'b0;
      tick;
      chk({7'h0, channel_status_irq[0]}, 8'h00);
      channel_status_irq_enable[0] = 1'b1;
      wr(8'h51, 8'h04);
      // an error in the same cycle as done blocks the flag
      for (int e = 0; e < 2; e++)
      begin
         rx_response_done[0] = 1'b1;
         rx_frame_error[0] = (e == 0);
         rx_checksum_error[0] = (e == 1);
         tick;
         {rx_response_done[0], rx_frame_error[0], rx_checksum_error[0]} = 3'h0;
         chk({6'h0, err_frame_set[0], err_checksum_set[0]}, (e == 0) ? 8'h02 : 8'h01);
         rd(8'h51, 8'h00);
      end
      // an error in an earlier cycle of the frame still blocks the flag
      rx_frame_error[0] = 1'b1;
      tick;
      {rx_frame_error[0], rx_response_done[0]} = 2'h1;
      tick;
      rx_response_done[0] = 1'b0;
      rd(8'h51, 8'h00);
      idle_on_bit_error[0] = 1'b1;
      tx_bit_error[0] = 1'b1;
      tick;
      {tx_bit_error[0], tx_response_done[0]} = 2'h1;
      tick;
      {idle_on_bit_error[0], tx_response_done[0]} = 2'h0;
      rd(8'h51, 8'h00);
      rx_complete_irq_enable[0] = 1'b0;
      tx_complete_irq_enable[0] = 1'b1;
      // bit error only blocks the tx flag with idle-on-error set
      for (int b = 0; b < 3; b++)
      begin
         idle_on_bit_error[0] = (b == 1);
         tx_bit_error[0] = (b != 0);
         tx_response_done[0] = 1'b1;
         tick;
         {tx_bit_error[0], tx_response_done[0]} = 2'h0;
         chk({7'h0, err_bit_set[0]}, (b != 0) ? 8'h01 : 8'h00);
         chk({7'h0, channel_status_irq[0]}, (b == 1) ? 8'h00 : 8'h01);
         rd(8'h51, (b == 1) ? 8'h00 : 8'h02);
         wr(8'h51, 8'h02);
      end
      // buffer flag from a stored byte, then from a master-sent response
      for (int m = 0; m < 2; m++)
      begin
         response_dir[0] = (m == 1);
         first_byte_stored[0] = (m == 0);
         tx_response_start[0] = (m == 1);
         tick;
         {first_byte_stored[0], tx_response_start[0]} = 2'h0;
         rd(8'h51, 8'h40);
         wr(8'h51, 8'h40);
         rd(8'h51, 8'h00);
      end
      // hardware set and clearing write in one cycle
      reg_addr = 8'h51;
      reg_wdata = 8'h04;
      {reg_wr, rx_response_done[0]} = 2'h3;
      tick;
      {reg_wr, rx_response_done[0]} = 2'h0;
      rd(8'h51, 8'h04);
      {first_byte_stored[0], tx_response_done[0]} = 2'h3;
      tick;
      {first_byte_stored[0], tx_response_done[0]} = 2'h0;
      rd(8'h51, 8'h46);
      init_mode[0] = 1'b1;
      rx_response_done[0] = 1'b1;
      tick;
      rx_response_done[0] = 1'b0;
      rd(8'h51, 8'h00);
      init_mode[0] = 1'b0;
      rd(8'h51, 8'h00);
      // bus drive follows the controller only in normal mode
      tx_active[0] = 1'b1;
      tx_bit[0] = 1'b0;
      tick;
      chk({7'h0, lin_tx_out[0]}, 8'h00);
      normal_mode[0] = 1'b0;
      tick;
      chk({7'h0, lin_tx_out[0]}, 8'h01);
      {normal_mode[0], tx_active[0], tx_bit[0]} = 3'h5;
      tick;
      chk({7'h0, lin_tx_out[0]}, 8'h01);
      // a slave holds the bus dominant until the termination is cut
      slave_dom[0] = 1'b1;
      n = 0;
      while (dom_timeout_active[0] !== 1'b1 && n < 40)
      begin
         tick;
         n++;
      end
      chk({7'h0, n >= TMO && n <= TMO + 3}, 8'h01);
      tick;
      chk({6'h0, master_pullup[0], weak_slave_pullup[0]}, 8'h01);
      slave_dom[0] = 1'b0;
      tick;
      chk({7'h0, dom_timeout_active[0]}, 8'h00);
      tick;
      chk({7'h0, master_pullup[0]}, 8'h01);
      // all four termination settings in both power modes
      for (int c = 0; c < 4; c++)
         for (int lp = 0; lp < 2; lp++)
         begin
            pullup_cfg[0] = 2'(c);
            low_power_mode[0] = lp[0];
            normal_mode[0] = !lp[0];
            term_exp = {c != 0 && (lp == 0 || c == 3), lp == 1 && c == 2};
            tick;
            tick;
            chk({6'h0, master_pullup[0], low_power_master_pullup[0]}, {6'h0, term_exp});
         end
      results;
   end
endmodule : lin_frame_status_flags_bench

//--- lin_status_monitor.sv
// lin_status_monitor: concurrent checks on the frame status block ports
// assumes binding into lin_frame_status_flags; channel 0 is the one watched, except the weak pull-up check on all four
`timescale 1ns/10ps
module lin_status_monitor
import lin_status_pkg::*;
#(
   parameter int unsigned DOM_TIMEOUT_CYCLES = 8
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [3:0] init_mode,
   input wire logic [3:0] normal_mode,
   input wire logic [3:0] low_power_mode,
   input wire logic [3:0] rx_complete_irq_enable,
   input wire logic [3:0] channel_status_irq_enable,
   input wire pullup_cfg_type [3:0] pullup_cfg,
   input wire logic [3:0] rx_response_done,
   input wire logic [3:0] rx_frame_error,
   input wire logic [3:0] rx_checksum_error,
   input wire logic [3:0] tx_bit_error,
   input wire logic [3:0] tx_active,
   input wire logic [3:0] tx_bit,
   input wire logic [3:0] bus_dominant,
   input wire logic [3:0] lin_tx_out,
   input wire logic [3:0] master_pullup,
   input wire logic [3:0] weak_slave_pullup,
   input wire logic [3:0] dom_timeout_active,
   input wire logic [3:0] channel_status_irq,
   input wire logic [3:0] err_frame_set,
   input wire logic [3:0] err_checksum_set,
   input wire logic [3:0] err_bit_set
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // run length of the dominant level, so the cut can be tied to its cause
   logic [31:0] dom_run;
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         dom_run <= '0;
      else if (bus_dominant[0])
         dom_run <= dom_run + 32'h1;
      else
         dom_run <= '0;
   end
   // framing or checksum error seen since the last done: that done sets no flag
   logic rx_err_pending;
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         rx_err_pending <= 1'b0;
      else if (rx_response_done[0] || init_mode[0])
         rx_err_pending <= 1'b0;
      else if (rx_frame_error[0] || rx_checksum_error[0])
         rx_err_pending <= 1'b1;
   end
   AST_RX_IRQ: assert property (rx_response_done[0] && !rx_frame_error[0]
      && !rx_checksum_error[0] && !init_mode[0] && rx_complete_irq_enable[0]
      && channel_status_irq_enable[0] && !rx_err_pending |=> channel_status_irq[0])
      else $error("rx done did not raise the status irq");
   AST_IRQ_OFF: assert property (!channel_status_irq_enable[0] |=> !channel_status_irq[0])
      else $error("status irq high with channel enable low");
   AST_FRAME_ERR: assert property (rx_frame_error[0] && !init_mode[0] |=> err_frame_set[0])
      else $error("frame error not passed on");
   AST_CKSUM_ERR: assert property (rx_checksum_error[0] && !init_mode[0] |=> err_checksum_set[0])
      else $error("checksum error not passed on");
   AST_BIT_ERR: assert property (tx_bit_error[0] && !init_mode[0] |=> err_bit_set[0])
      else $error("bit error not passed on");
   AST_TX_LINE: assert property (1'b1 |=> lin_tx_out[0] ==
      ($past(normal_mode[0] & tx_active[0]) ? $past(tx_bit[0]) : 1'b1))
      else $error("bus output not recessive while idle");
   AST_DOM_LEN: assert property ($rose(dom_timeout_active[0]) |-> dom_run >= DOM_TIMEOUT_CYCLES)
      else $error("termination cut before the dominant timeout");
   AST_DOM_CUT: assert property (dom_timeout_active[0] |=> !master_pullup[0])
      else $error("master pull-up kept after dominant timeout");
   AST_SLAVE_ON: assert property (1'b1 |=> weak_slave_pullup == 4'hf)
      else $error("weak pull-up dropped");
   AST_DOM_REL: assert property (!bus_dominant[0] |=> !dom_timeout_active[0])
      else $error("timeout not released on recessive bus");
   AST_RESTORE: assert property ($fell(dom_timeout_active[0]) && pullup_cfg[0] != 2'h0
      && !low_power_mode[0] |=> master_pullup[0])
      else $error("master pull-up not restored");
   AST_INIT_CLR: assert property (init_mode[0] |=> !channel_status_irq[0])
      else $error("status irq survives init mode");
   COV_IRQ: cover property (channel_status_irq[0]);
   COV_DOM: cover property ($rose(dom_timeout_active[0]));
   COV_INIT: cover property (init_mode[0] ##1 !init_mode[0]);
endmodule : lin_status_monitor

bind lin_frame_status_flags lin_status_monitor #(.DOM_TIMEOUT_CYCLES(DOM_TIMEOUT_CYCLES))
   i_lin_status_monitor (.clk_sys, .rst_b, .init_mode, .normal_mode, .low_power_mode,
   .rx_complete_irq_enable, .channel_status_irq_enable, .pullup_cfg, .rx_response_done,
   .rx_frame_error, .rx_checksum_error, .tx_bit_error, .tx_active, .tx_bit, .bus_dominant,
   .lin_tx_out, .master_pullup, .weak_slave_pullup, .dom_timeout_active,
   .channel_status_irq, .err_frame_set, .err_checksum_set, .err_bit_set);

//--- lin_status_pkg.sv
// lin_status_pkg: state types shared by the frame status block
// assumes lin_status_regs.svh is included first for field widths
`include "lin_status_regs.svh"

package lin_status_pkg;
   // termination setting code, one per channel
   typedef logic [1:0] pullup_cfg_type;
   // per-channel flag and frame tracking state
   typedef struct packed {
      logic rx_done_flag; // reception complete
      logic tx_done_flag; // transmission complete
      logic rxbuf_flag; // reception buffer not empty
      logic rx_err_seen; // framing/checksum error in current frame
      logic tx_err_seen; // bit error in current frame
      logic status_irq; // registered status interrupt
      logic tx_line; // registered bus output
      logic err_frame; // error register set pulses
      logic err_checksum;
      logic err_bit;
   } chan_state_type;
   // whole state of the top module
   typedef struct packed {
      chan_state_type [3:0] chan;
      logic [7:0] rdata;
      logic rvalid;
   } top_state_type;
   // dominant timeout guard modes
   typedef enum logic {TERM_CONNECTED, TERM_DISCONNECTED} dom_mode_type;
   typedef struct packed {
      dom_mode_type mode;
      logic [`DOM_CNT_W-1:0] count;
   } dom_state_type;
   // registered termination switches
   typedef struct packed {
      logic master_on;
      logic lp_master_on;
      logic slave_on;
   } term_state_type;
endpackage : lin_status_pkg

//--- lin_status_regs.svh
// lin_status_regs.svh: offsets, field positions, reset values and timing counts
// assumes the including file also imports lin_status_pkg for the types
`ifndef LIN_STATUS_REGS_SVH
`define LIN_STATUS_REGS_SVH

`define CH1_STATUS_OFFS 8'h51
`define CH2_STATUS_OFFS 8'h81
`define CH3_STATUS_OFFS 8'hb1
`define CH4_STATUS_OFFS 8'he1
`define RXBUF_BIT 6
`define RXDONE_BIT 2
`define TXDONE_BIT 1
`define STATUS_RESET 8'h00
`define PULLUP_OFF 2'h0
`define PULLUP_NORMAL_ONLY 2'h1
`define PULLUP_NORMAL_LP 2'h2
`define PULLUP_ALWAYS 2'h3
`define CLK_PERIOD_NS 40
`define DOM_TIMEOUT_US 6000 // plain default, set to the product's own limit
`define DOM_TIMEOUT_CYCLES ((`DOM_TIMEOUT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DOM_CNT_W 24

`endif

//--- termination_select.sv
// termination_select: chooses which pull-ups one channel connects
// assumes low_power reflects the device power mode synchronously
`timescale 1ns/10ps
`include "lin_status_regs.svh"

module termination_select
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire lin_status_pkg::pullup_cfg_type cfg,
   input wire logic low_power,
   input wire logic term_allowed,
   output logic master_on,
   output logic lp_master_on,
   output logic slave_on
);
   import lin_status_pkg::*;

   term_state_type state_reg; // registered switches
   term_state_type state_next; // next switches

   // decode the setting; the weak pull-up is on from the first edge after reset
   always_comb
   begin
      state_next = '0;
      state_next.slave_on = 1'b1;
      unique case (cfg)
         `PULLUP_OFF: state_next.master_on = 1'b0;
         `PULLUP_NORMAL_ONLY: state_next.master_on = !low_power;
         `PULLUP_NORMAL_LP:
         begin
            state_next.master_on = !low_power;
            state_next.lp_master_on = low_power;
         end
         `PULLUP_ALWAYS: state_next.master_on = 1'b1;
      endcase
      // the timeout overrides any setting while the bus hangs dominant
      state_next.master_on = state_next.master_on & term_allowed;
      state_next.lp_master_on = state_next.lp_master_on & term_allowed;
   end

   // switch register
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign master_on = state_reg.master_on;
   assign lp_master_on = state_reg.lp_master_on;
   assign slave_on = state_reg.slave_on;
endmodule : termination_select
